// >>> hw/t16c_pin_filter.sv
// pin synchroniser with optional equal-sample noise filter
`timescale 1ns/1ps
module t16c_pin_filter
#(
	parameter int FILT_LEN = t16c_pkg::FILT_LEN
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// pin and control
	input wire logic pinIn,
	input wire logic filtEn,
	// clean level
	output logic level
);
	logic syncA;
	logic syncB;
	logic syncC;
	logic syncLvl;
	logic [FILT_LEN-1:0] hist;

	// ========================================
	// synchroniser, syncA is read by syncB only
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			syncA <= 1'b0;
			syncB <= 1'b0;
			syncC <= 1'b0;
			syncLvl <= 1'b0;
		end
		else
		begin
			syncA <= pinIn;
			syncB <= syncA;
			syncC <= syncB;
			if (syncB == syncC)
				syncLvl <= syncC;
		end
	end

	// ========================================
	// filter: a change needs a full run of equal samples
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			hist <= '0;
			level <= 1'b0;
		end
		else
		begin
			hist <= {hist[FILT_LEN-2:0], syncLvl};
			if (!filtEn)
				level <= syncLvl;
			else if (&hist)
				level <= 1'b1; // RULE14
			else if (~|hist)
				level <= 1'b0; // RULE14
		end
	end

	// ========================================
	// assertions
	property p_filt_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		(filtEn && !level && !(&hist)) |=> !level;
	endproperty
	a_filt_hold: assert property (p_filt_hold) else $error("filter rose early"); // RULE14
endmodule // t16c_pin_filter

// >>> hw/t16c_timer_ctrl.sv
// timer16 waveform mode, compare output and capture control with ahb-lite registers
`timescale 1ns/1ps
module t16c_timer_ctrl
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// pins
	input wire logic captureInPin,
	input wire logic extTickPin,
	output logic waveOutA,
	output logic waveOvrA,
	output logic waveOutB,
	output logic waveOvrB,
	// interrupt
	output logic irq
);
	logic [7:0] timerControlA;
	logic [7:0] timerControlB;
	logic [15:0] bufA, bufB, compareValueA, compareValueB, captureValue, countValue;
	localparam int ST_W_LOC = t16c_pkg::ST_W;
	logic [ST_W_LOC-1:0] irqStatus, irqMask;
	logic [1:0] chanAOutputAction, chanBOutputAction;
	logic [3:0] waveModeSelect;
	logic [2:0] tickSourceSel;
	logic waveModeTopBit, captureFilterEn, captureEdgeSel;
	t16c_pkg::t16c_kind_t kind;
	t16c_pkg::t16c_upd_t upd;
	t16c_pkg::t16c_dir_t dir;
	logic [15:0] topVal, fixedTop;
	logic icrTop, tick, atTop, atBot, matchA, matchB, wrapEv, loadEv, blockMatch;
	logic [9:0] preCnt;
	logic extLvl, extPrev, capLvl, capPrev, capEv, forceA, forceB;
	logic wrOn, addrOk;
	logic [7:0] wrIdx, addrIdx;
	logic [31:0] rdMux;
	logic [ST_W_LOC-1:0] evt, clr;

	// ========================================
	// field views
	assign chanAOutputAction = timerControlA[t16c_pkg::ACT_A_LO+:2];
	assign chanBOutputAction = timerControlA[t16c_pkg::ACT_B_LO+:2];
	assign waveModeSelect = {timerControlB[t16c_pkg::WM_HI+:2], timerControlA[t16c_pkg::WM_LO+:2]}; // RULE13
	assign waveModeTopBit = timerControlB[t16c_pkg::WM_TOP];
	assign captureFilterEn = timerControlB[t16c_pkg::FILT_EN];
	assign captureEdgeSel = timerControlB[t16c_pkg::EDGE_SEL];
	assign tickSourceSel = timerControlB[t16c_pkg::CS_LO+:3];

	// ========================================
	// mode decode: count shape, TOP source, buffer update point
	always_comb
	begin
		case (waveModeSelect[1:0])
			2'h1: fixedTop = t16c_pkg::TOP_8;
			2'h2: fixedTop = t16c_pkg::TOP_9;
			default: fixedTop = t16c_pkg::TOP_10;
		endcase
	end

	always_comb
	begin
		kind = t16c_pkg::KIND_NORMAL;
		upd = t16c_pkg::UPD_NOW;
		topVal = t16c_pkg::TOP_MAX;
		icrTop = 1'b0;
		case (waveModeSelect)
			t16c_pkg::MODE_NORMAL:
				topVal = t16c_pkg::TOP_MAX; // RULE10
			t16c_pkg::MODE_PC8, t16c_pkg::MODE_PC9, t16c_pkg::MODE_PC10:
			begin
				kind = t16c_pkg::KIND_DUAL; // RULE8
				upd = t16c_pkg::UPD_TOP;
				topVal = fixedTop;
			end
			t16c_pkg::MODE_CTC_A:
				topVal = compareValueA; // RULE10
			t16c_pkg::MODE_FAST8, t16c_pkg::MODE_FAST9, t16c_pkg::MODE_FAST10:
			begin
				kind = t16c_pkg::KIND_FAST; // RULE9
				upd = t16c_pkg::UPD_BOT;
				topVal = fixedTop;
			end
			t16c_pkg::MODE_PFC_C, t16c_pkg::MODE_PFC_A:
			begin
				kind = t16c_pkg::KIND_DUAL; // RULE11
				upd = t16c_pkg::UPD_BOT;
				icrTop = !waveModeSelect[0];
				topVal = waveModeSelect[0] ? compareValueA : captureValue;
			end
			t16c_pkg::MODE_PC_C, t16c_pkg::MODE_PC_A:
			begin
				kind = t16c_pkg::KIND_DUAL; // RULE12
				upd = t16c_pkg::UPD_TOP;
				icrTop = !waveModeSelect[0];
				topVal = waveModeSelect[0] ? compareValueA : captureValue;
			end
			t16c_pkg::MODE_CTC_C:
			begin
				icrTop = 1'b1; // RULE10
				topVal = captureValue;
			end
			t16c_pkg::MODE_FAST_C, t16c_pkg::MODE_FAST_A:
			begin
				kind = t16c_pkg::KIND_FAST; // RULE12
				upd = t16c_pkg::UPD_BOT;
				icrTop = !waveModeSelect[0];
				topVal = waveModeSelect[0] ? compareValueA : captureValue;
			end
			default:
				kind = t16c_pkg::KIND_RSVD; // RULE12
		endcase
	end

	// ========================================
	// prescaler and tick select
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			preCnt <= 10'h000;
		else
			preCnt <= preCnt + 10'h001;
	end

	always_comb
	begin
		case (tickSourceSel) // RULE16
			t16c_pkg::CS_STOP: tick = 1'b0;
			t16c_pkg::CS_DIV1: tick = 1'b1;
			t16c_pkg::CS_DIV8: tick = &preCnt[t16c_pkg::PRE_W8-1:0];
			t16c_pkg::CS_DIV64: tick = &preCnt[t16c_pkg::PRE_W64-1:0];
			t16c_pkg::CS_DIV256: tick = &preCnt[t16c_pkg::PRE_W256-1:0];
			t16c_pkg::CS_DIV1024: tick = &preCnt[t16c_pkg::PRE_W1024-1:0];
			t16c_pkg::CS_EXT_FALL: tick = extPrev && !extLvl;
			t16c_pkg::CS_EXT_RISE: tick = !extPrev && extLvl;
			default: tick = 1'b0;
		endcase
	end

	// external tick pin, synchronised, never filtered
	t16c_pin_filter u_ext_sync
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pinIn(extTickPin),
		.filtEn(1'b0),
		.level(extLvl)
	);

	// last external level; resets to the idle low level so no false edge follows reset
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			extPrev <= 1'b0;
		else
			extPrev <= extLvl; // RULE16
	end

	// ========================================
	// counter events
	assign atTop = countValue == topVal;
	assign atBot = countValue == 16'h0000;
	assign matchA = tick && !blockMatch && countValue == compareValueA;
	assign matchB = tick && !blockMatch && countValue == compareValueB;

	always_comb
	begin
		case (kind)
			t16c_pkg::KIND_NORMAL: wrapEv = tick && countValue == t16c_pkg::TOP_MAX; // RULE10
			t16c_pkg::KIND_FAST: wrapEv = tick && atTop; // RULE9
			t16c_pkg::KIND_DUAL: wrapEv = tick && atBot && dir == t16c_pkg::DIR_DOWN; // RULE8
			default: wrapEv = 1'b0;
		endcase
	end

	// buffer load point per mode
	always_comb
	begin
		case (upd)
			t16c_pkg::UPD_TOP: loadEv = tick && atTop;
			t16c_pkg::UPD_BOT:
				loadEv = (kind == t16c_pkg::KIND_FAST) ? tick && atTop
					: tick && atBot && dir == t16c_pkg::DIR_DOWN; // RULE11
			default: loadEv = 1'b1;
		endcase
	end

	// ========================================
	// counter; a software write wins over a tick
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			countValue <= 16'h0000;
			dir <= t16c_pkg::DIR_UP;
		end
		else if (wrOn && wrIdx == t16c_pkg::IDX_COUNT)
			countValue <= hwdata[15:0];
		else if (tick)
		begin
			case (kind)
				t16c_pkg::KIND_NORMAL, t16c_pkg::KIND_FAST:
				begin
					dir <= t16c_pkg::DIR_UP;
					countValue <= atTop ? 16'h0000 : countValue + 16'h0001; // RULE10
				end
				t16c_pkg::KIND_DUAL:
				begin
					if ((dir == t16c_pkg::DIR_UP && !atTop) || (dir == t16c_pkg::DIR_DOWN && atBot))
					begin
						dir <= t16c_pkg::DIR_UP;
						countValue <= countValue + 16'h0001;
					end
					else
					begin
						dir <= t16c_pkg::DIR_DOWN; // RULE8
						countValue <= countValue - 16'h0001;
					end
				end
				default:
					countValue <= countValue;
			endcase
		end
	end

	// a count write hides the match on the next tick
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			blockMatch <= 1'b0;
		else if (wrOn && wrIdx == t16c_pkg::IDX_COUNT)
			blockMatch <= 1'b1;
		else if (tick)
			blockMatch <= 1'b0;
	end

	// ========================================
	// compare buffers, software sees the buffer
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			bufA <= 16'h0000;
			bufB <= 16'h0000;
			compareValueA <= 16'h0000;
			compareValueB <= 16'h0000;
		end
		else
		begin
			if (wrOn && wrIdx == t16c_pkg::IDX_CMP_A)
				bufA <= hwdata[15:0];
			if (wrOn && wrIdx == t16c_pkg::IDX_CMP_B)
				bufB <= hwdata[15:0];
			if (loadEv)
			begin
				compareValueA <= bufA; // RULE9
				compareValueB <= bufB;
			end
		end
	end

	// ========================================
	// capture; off while the capture register is TOP
	t16c_pin_filter u_capt_filt
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pinIn(captureInPin),
		.filtEn(captureFilterEn),
		.level(capLvl)
	);

	assign capEv = !icrTop && (captureEdgeSel ? capLvl && !capPrev : !capLvl && capPrev); // RULE15

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			capPrev <= 1'b0;
			captureValue <= 16'h0000;
		end
		else
		begin
			capPrev <= capLvl;
			if (capEv)
				captureValue <= countValue; // RULE15
			else if (wrOn && wrIdx == t16c_pkg::IDX_CAPT)
				captureValue <= hwdata[15:0];
		end
	end

	// ========================================
	// compare outputs
	assign forceA = wrOn && wrIdx == t16c_pkg::IDX_FORCE && hwdata[t16c_pkg::FRC_A];
	assign forceB = wrOn && wrIdx == t16c_pkg::IDX_FORCE && hwdata[t16c_pkg::FRC_B];

	function automatic logic waveNext(input logic [1:0] act, input logic cur,
		input logic hit, input logic frc, input logic isA);
		logic r;
		r = cur;
		if (kind == t16c_pkg::KIND_NORMAL)
		begin
			if (hit || frc)
			begin
				case (act) // RULE3
					t16c_pkg::ACT_TOGGLE: r = !cur;
					t16c_pkg::ACT_CLEAR: r = 1'b0;
					t16c_pkg::ACT_SET: r = 1'b1;
					default: r = cur;
				endcase
			end
		end
		else if (kind != t16c_pkg::KIND_RSVD)
		begin
			if (act == t16c_pkg::ACT_TOGGLE)
				r = (isA && waveModeTopBit && hit) ? !cur : cur; // RULE5
			else if (act[1] && kind == t16c_pkg::KIND_FAST && tick && atTop)
				r = !act[0]; // RULE4 RULE6
			else if (act[1] && hit)
				r = (kind == t16c_pkg::KIND_DUAL && dir == t16c_pkg::DIR_DOWN) ? !act[0] : act[0]; // RULE7
		end
		return r;
	endfunction

	function automatic logic ovrNext(input logic [1:0] act, input logic isA);
		logic r;
		r = act != t16c_pkg::ACT_OFF; // RULE1
		if (kind != t16c_pkg::KIND_NORMAL && kind != t16c_pkg::KIND_RSVD && act == t16c_pkg::ACT_TOGGLE)
			r = isA && waveModeTopBit; // RULE5
		return r;
	endfunction

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			waveOutA <= 1'b0;
			waveOutB <= 1'b0;
			waveOvrA <= 1'b0;
			waveOvrB <= 1'b0;
		end
		else
		begin
			waveOutA <= waveNext(chanAOutputAction, waveOutA, matchA, forceA, 1'b1);
			waveOutB <= waveNext(chanBOutputAction, waveOutB, matchB, forceB, 1'b0);
			waveOvrA <= ovrNext(chanAOutputAction, 1'b1);
			waveOvrB <= ovrNext(chanBOutputAction, 1'b0);
		end
	end

	// ========================================
	// interrupt status, a new event beats a same-cycle clear
	assign evt = {capEv, matchB, matchA, wrapEv};
	assign clr = (wrOn && wrIdx == t16c_pkg::IDX_STAT) ? hwdata[ST_W_LOC-1:0] : '0;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			irqStatus <= '0;
			irqMask <= '0;
			irq <= 1'b0;
		end
		else
		begin
			irqStatus <= (irqStatus & ~clr) | evt;
			if (wrOn && wrIdx == t16c_pkg::IDX_MASK)
				irqMask <= hwdata[ST_W_LOC-1:0];
			irq <= |(irqStatus & irqMask);
		end
	end

	// ========================================
	// ahb-lite slave: zero wait, read data registered in the address phase
	assign addrOk = hsel && htrans[1] && hready;
	assign addrIdx = (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0) ? haddr[9:2]
		: t16c_pkg::IDX_NONE;

	always_comb
	begin
		case (addrIdx)
			t16c_pkg::IDX_CTL_A: rdMux = {24'h000000, timerControlA};
			t16c_pkg::IDX_CTL_B: rdMux = {24'h000000, timerControlB};
			t16c_pkg::IDX_CMP_A: rdMux = {16'h0000, bufA};
			t16c_pkg::IDX_CMP_B: rdMux = {16'h0000, bufB};
			t16c_pkg::IDX_CAPT: rdMux = {16'h0000, captureValue};
			t16c_pkg::IDX_COUNT: rdMux = {16'h0000, countValue};
			t16c_pkg::IDX_STAT: rdMux = {28'h0000000, irqStatus};
			t16c_pkg::IDX_MASK: rdMux = {28'h0000000, irqMask};
			default: rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			wrOn <= 1'b0;
			wrIdx <= t16c_pkg::IDX_NONE;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wrOn <= addrOk && hwrite;
			wrIdx <= addrIdx;
			hrdata <= (addrOk && !hwrite) ? rdMux : 32'h00000000;
		end
	end

	// control registers, reserved bits stay zero
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			timerControlA <= t16c_pkg::CTL_RESET;
			timerControlB <= t16c_pkg::CTL_RESET;
		end
		else if (wrOn && wrIdx == t16c_pkg::IDX_CTL_A)
			timerControlA <= hwdata[7:0] & t16c_pkg::CTL_A_WMASK;
		else if (wrOn && wrIdx == t16c_pkg::IDX_CTL_B)
			timerControlB <= hwdata[7:0] & t16c_pkg::CTL_B_WMASK;
	end

	// ========================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_ovr_on;
		(kind == t16c_pkg::KIND_NORMAL && chanAOutputAction != t16c_pkg::ACT_OFF) |=> waveOvrA;
	endproperty
	a_ovr_on: assert property (p_ovr_on) else $error("override missing"); // RULE1
	property p_np_clear;
		(kind == t16c_pkg::KIND_NORMAL && matchA && chanAOutputAction == t16c_pkg::ACT_CLEAR)
			|=> !waveOutA;
	endproperty
	a_np_clear: assert property (p_np_clear) else $error("clear on match failed"); // RULE3
	property p_np_toggle;
		(kind == t16c_pkg::KIND_NORMAL && matchA && chanAOutputAction == t16c_pkg::ACT_TOGGLE)
			|=> waveOutA != $past(waveOutA);
	endproperty
	a_np_toggle: assert property (p_np_toggle) else $error("toggle failed"); // RULE3
	property p_fast_bot;
		(kind == t16c_pkg::KIND_FAST && tick && atTop && chanAOutputAction == t16c_pkg::ACT_CLEAR)
			|=> waveOutA;
	endproperty
	a_fast_bot: assert property (p_fast_bot) else $error("bottom set failed"); // RULE4
	property p_fast_ign;
		(kind == t16c_pkg::KIND_FAST && matchA && atTop && chanAOutputAction == t16c_pkg::ACT_SET)
			|=> !waveOutA;
	endproperty
	a_fast_ign: assert property (p_fast_ign) else $error("top match not ignored"); // RULE6
	property p_b_disc;
		(kind == t16c_pkg::KIND_DUAL && chanBOutputAction == t16c_pkg::ACT_TOGGLE) |=> !waveOvrB;
	endproperty
	a_b_disc: assert property (p_b_disc) else $error("channel b not disconnected"); // RULE5
	property p_dual_up;
		(kind == t16c_pkg::KIND_DUAL && matchA && dir == t16c_pkg::DIR_UP
			&& chanAOutputAction == t16c_pkg::ACT_CLEAR) |=> !waveOutA;
	endproperty
	a_dual_up: assert property (p_dual_up) else $error("up match clear failed"); // RULE7
	property p_dual_wrap;
		(kind == t16c_pkg::KIND_DUAL && tick && atBot && dir == t16c_pkg::DIR_DOWN)
			|=> irqStatus[t16c_pkg::ST_WRAP] ##1 irq || !irqMask[t16c_pkg::ST_WRAP];
	endproperty
	a_dual_wrap: assert property (p_dual_wrap) else $error("wrap at bottom missing"); // RULE8
	property p_fast_wrap;
		(kind == t16c_pkg::KIND_FAST && tick && atTop && !wrOn)
			|=> countValue == 16'h0000 && irqStatus[t16c_pkg::ST_WRAP];
	endproperty
	a_fast_wrap: assert property (p_fast_wrap) else $error("fast wrap wrong"); // RULE9
	property p_capt;
		capEv && !wrOn |=> captureValue == $past(countValue) && irqStatus[t16c_pkg::ST_CAPT];
	endproperty
	a_capt: assert property (p_capt) else $error("capture wrong"); // RULE15
	property p_stop;
		(tickSourceSel == t16c_pkg::CS_STOP && !wrOn) [*2] |-> $stable(countValue);
	endproperty
	a_stop: assert property (p_stop) else $error("stopped timer moved"); // RULE16
	c_capt: cover property (capEv);
	c_fast_bot: cover property (kind == t16c_pkg::KIND_FAST && tick && atTop);
	c_dual_turn: cover property (kind == t16c_pkg::KIND_DUAL && tick && atTop ##1 dir == t16c_pkg::DIR_DOWN);
	c_irq: cover property ($rose(irq));
endmodule // t16c_timer_ctrl

// >>> inc/t16c_pkg.sv
// constants and types for the 16-bit timer mode and compare output control
// Function
// RULE1: A nonzero output action field gives that channel's pin to the waveform output.
// RULE2: Software must make the compare pin an output before the waveform reaches the pin.
// RULE3: In normal and clear-on-match modes action 00 disconnects, 01 toggles, 10 clears, 11 sets.
// RULE4: In fast PWM, 10 clears on match and sets at bottom; 11 sets on match and clears at bottom.
// RULE5: In PWM modes action 01 disconnects unless the top mode bit is set, then only A toggles.
// RULE6: In fast PWM a match at a compare value equal to TOP is ignored but the bottom action runs.
// RULE7: In dual-slope modes 10 clears on an up match and sets on a down match; 11 does the inverse.
// RULE8: Modes 1 to 3 count dual-slope to 0x00FF, 0x01FF, 0x03FF, load at TOP, wrap at BOTTOM.
// RULE9: Modes 5 to 7 are fast PWM with 8, 9, 10 bit TOP, load at BOTTOM, wrap flag at TOP.
// RULE10: Mode 0 runs to 0xFFFF, modes 4 and 12 clear on compare A or capture, all load at once.
// RULE11: Modes 8 and 9 are dual-slope with TOP from capture or compare A, load and wrap at BOTTOM.
// RULE12: Modes 10 and 11 are dual-slope loading at TOP, 14 and 15 fast PWM, 13 is reserved.
// RULE13: The mode number is control B bits 4:3 above control A bits 1:0.
// RULE14: With the filter on, the capture input changes only after four equal samples.
// RULE15: The edge select picks falling at 0 or rising at 1; a capture copies the count and flags.
// RULE16: Clock select 0 stops, 1 to 5 divide by 1, 8, 64, 256, 1024, 6 and 7 take external edges.
package t16c_pkg;
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_CTL_B = 8'h2E;
	localparam logic [7:0] IDX_CTL_A = 8'h2F;
	localparam logic [7:0] IDX_CMP_A = 8'h30;
	localparam logic [7:0] IDX_CMP_B = 8'h31;
	localparam logic [7:0] IDX_CAPT = 8'h32;
	localparam logic [7:0] IDX_COUNT = 8'h33;
	localparam logic [7:0] IDX_STAT = 8'h34;
	localparam logic [7:0] IDX_MASK = 8'h35;
	localparam logic [7:0] IDX_FORCE = 8'h36;
	localparam logic [7:0] IDX_NONE = 8'hFF;
	// control reset values and writable bits
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] CTL_A_WMASK = 8'hF3;
	localparam logic [7:0] CTL_B_WMASK = 8'hDF;
	// field positions
	localparam int ACT_A_LO = 6;
	localparam int ACT_B_LO = 4;
	localparam int WM_LO = 0;
	localparam int WM_HI = 3;
	localparam int WM_TOP = 4;
	localparam int FILT_EN = 7;
	localparam int EDGE_SEL = 6;
	localparam int CS_LO = 0;
	localparam int FRC_A = 0;
	localparam int FRC_B = 1;
	// status and mask bits
	localparam int ST_WRAP = 0;
	localparam int ST_MATCH_A = 1;
	localparam int ST_MATCH_B = 2;
	localparam int ST_CAPT = 3;
	localparam int ST_W = 4;
	// waveform modes
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_PC8 = 4'h1;
	localparam logic [3:0] MODE_PC9 = 4'h2;
	localparam logic [3:0] MODE_PC10 = 4'h3;
	localparam logic [3:0] MODE_CTC_A = 4'h4;
	localparam logic [3:0] MODE_FAST8 = 4'h5;
	localparam logic [3:0] MODE_FAST9 = 4'h6;
	localparam logic [3:0] MODE_FAST10 = 4'h7;
	localparam logic [3:0] MODE_PFC_C = 4'h8;
	localparam logic [3:0] MODE_PFC_A = 4'h9;
	localparam logic [3:0] MODE_PC_C = 4'hA;
	localparam logic [3:0] MODE_PC_A = 4'hB;
	localparam logic [3:0] MODE_CTC_C = 4'hC;
	localparam logic [3:0] MODE_RSVD = 4'hD;
	localparam logic [3:0] MODE_FAST_C = 4'hE;
	localparam logic [3:0] MODE_FAST_A = 4'hF;
	// fixed TOP values
	localparam logic [15:0] TOP_8 = 16'h00FF;
	localparam logic [15:0] TOP_9 = 16'h01FF;
	localparam logic [15:0] TOP_10 = 16'h03FF;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	// output actions
	localparam logic [1:0] ACT_OFF = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	// tick sources and prescaler widths
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRE_W8 = 3;
	localparam int PRE_W64 = 6;
	localparam int PRE_W256 = 8;
	localparam int PRE_W1024 = 10;
	// capture filter length in samples
	localparam int FILT_LEN = 4;
	typedef enum logic [1:0] {KIND_NORMAL, KIND_FAST, KIND_DUAL, KIND_RSVD} t16c_kind_t;
	typedef enum logic [1:0] {UPD_NOW, UPD_TOP, UPD_BOT} t16c_upd_t;
	typedef enum logic {DIR_UP, DIR_DOWN} t16c_dir_t;
endpackage

// >>> tb/t16c_tb.sv
// self-checking testbench for the timer16 mode and compare output control
`timescale 1ns/1ps
module tb;
	// ==========================================================
	// clock, reset, bus and pins
	logic sysClk = 1'b0;
	logic rstN = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic capPin = 1'b0;
	logic extPin = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, outA, ovrA, outB, ovrB, irq;
	int numErrors = 0;
	int checks = 0;
	// single slave, so its ready is the bus ready
	t16c_timer_ctrl dut (.sys_clk(sysClk), .rst_n(rstN), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .captureInPin(capPin),
		.extTickPin(extPin), .waveOutA(outA), .waveOvrA(ovrA), .waveOutB(outB),
		.waveOvrB(ovrB), .irq(irq));
	initial forever #4 sysClk = ~sysClk;
	// ==========================================================
	// shared tasks
	task automatic wrap_up();
		if (numErrors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			numErrors++;
		end
	endtask
	// one single word transfer, address phase then data phase
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge sysClk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		do @(posedge sysClk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge sysClk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("response", 32'h0, {31'h0, hresp});
	endtask
	task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		bus(idx, 1'b0, 32'h0, d);
		chk(name, exp, d);
	endtask
	task automatic setMode(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] ab,
		input logic [1:0] hiB, input logic [2:0] cs);
		logic [31:0] d;
		bus(t16c_pkg::IDX_CTL_A, 1'b1, {24'h0, aa, ab, 2'h0, m[1:0]}, d);
		bus(t16c_pkg::IDX_CTL_B, 1'b1, {24'h0, hiB, 1'b0, m[3:2], cs}, d);
	endtask
	// ==========================================================
	// scenarios
	task automatic regs();
		logic [31:0] d;
		rdchk("control a reset", t16c_pkg::IDX_CTL_A, 32'h00);
		rdchk("control b reset", t16c_pkg::IDX_CTL_B, 32'h00);
		bus(t16c_pkg::IDX_CTL_A, 1'b1, 32'hFF, d);
		bus(t16c_pkg::IDX_CTL_B, 1'b1, 32'hFF, d);
		rdchk("control a access", t16c_pkg::IDX_CTL_A, 32'hF3);
		rdchk("control b access", t16c_pkg::IDX_CTL_B, 32'hDF);
		rdchk("unmapped read", t16c_pkg::IDX_NONE, 32'h0);
		setMode(4'h0, 2'h0, 2'h0, 2'h0, 3'h0);
	endtask
	// pin ownership per mode and action: mode, act a, act b, expected a and b
	task automatic ovr();
		logic [9:0] t [4] = '{10'b0000_01_00_10, 10'b0101_01_01_00,
			10'b1111_01_01_10, 10'b0101_10_11_11};
		for (int i = 0; i < 4; i++)
		begin
			setMode(t[i][9:6], t[i][5:4], t[i][3:2], 2'h0, 3'h0);
			repeat (2) @(posedge sysClk);
			chk("override", {30'h0, t[i][1:0]}, {30'h0, ovrA, ovrB});
		end
	endtask
	// high time of outputs a and b over one steady period
	task automatic pwm(input logic [3:0] m, input logic [1:0] aa, input logic [15:0] cmp,
		input int per, input int expHigh);
		logic [31:0] d;
		int n;
		int nB;
		n = 0;
		nB = 0;
		setMode(4'h0, 2'h0, 2'h0, 2'h0, 3'h0);
		bus(t16c_pkg::IDX_COUNT, 1'b1, 32'h0, d);
		bus(t16c_pkg::IDX_CMP_A, 1'b1, {16'h0, cmp}, d);
		bus(t16c_pkg::IDX_CMP_B, 1'b1, {16'h0, cmp}, d);
		setMode(m, aa, aa, 2'h0, t16c_pkg::CS_DIV1);
		repeat (3 * per) @(posedge sysClk);
		repeat (per)
		begin
			@(posedge sysClk);
			if (outA === 1'b1)
				n++;
			if (outB === 1'b1)
				nB++;
		end
		chk("high time", expHigh, n);
		chk("high time b", expHigh, nB);
	endtask
	// capture pulse through the optional filter, status bit and interrupt
	task automatic capt(input logic filt, input int w, input logic m, input logic e,
		input logic eIrq);
		logic [31:0] d;
		setMode(4'h0, 2'h0, 2'h0, {filt, 1'b1}, t16c_pkg::CS_DIV1);
		bus(t16c_pkg::IDX_MASK, 1'b1, {28'h0, m, 3'h0}, d);
		bus(t16c_pkg::IDX_STAT, 1'b1, 32'h8, d);
		repeat (8) @(posedge sysClk);
		capPin <= 1'b1;
		repeat (w) @(posedge sysClk);
		capPin <= 1'b0;
		repeat (12) @(posedge sysClk);
		bus(t16c_pkg::IDX_STAT, 1'b0, 32'h0, d);
		chk("capture flag", {28'h0, e, 3'h0}, d & 32'h8);
		chk("irq raised", {31'h0, eIrq}, {31'h0, irq});
		bus(t16c_pkg::IDX_STAT, 1'b1, 32'h8, d);
		repeat (3) @(posedge sysClk);
		chk("irq cleared", 32'h0, {31'h0, irq});
	endtask
	// external pin edges clock the counter, one count per chosen edge
	task automatic ext();
		logic [31:0] d;
		for (int cs = 6; cs <= 7; cs++)
		begin
			setMode(4'h0, 2'h0, 2'h0, 2'h0, t16c_pkg::CS_STOP);
			bus(t16c_pkg::IDX_COUNT, 1'b1, 32'h0, d);
			setMode(4'h0, 2'h0, 2'h0, 2'h0, cs[2:0]);
			repeat (5)
			begin
				extPin <= 1'b1;
				repeat (6) @(posedge sysClk);
				extPin <= 1'b0;
				repeat (6) @(posedge sysClk);
			end
			setMode(4'h0, 2'h0, 2'h0, 2'h0, t16c_pkg::CS_STOP);
			rdchk("external ticks", t16c_pkg::IDX_COUNT, 32'h5);
		end
	endtask
	// counts reached by each prescaler setting in a fixed span
	task automatic ticks();
		logic [31:0] d;
		int e;
		for (int cs = 1; cs <= 5; cs++)
		begin
			e = 2048 >> (cs == 1 ? 0 : (cs == 2 ? 3 : (cs == 3 ? 6 : (cs == 4 ? 8 : 10))));
			setMode(4'h0, 2'h0, 2'h0, 2'h0, 3'h0);
			bus(t16c_pkg::IDX_COUNT, 1'b1, 32'h0, d);
			setMode(4'h0, 2'h0, 2'h0, 2'h0, cs[2:0]);
			repeat (2048) @(posedge sysClk);
			setMode(4'h0, 2'h0, 2'h0, 2'h0, 3'h0);
			bus(t16c_pkg::IDX_COUNT, 1'b0, 32'h0, d);
			chk("tick count", 32'h1, {31'h0, (d >= e - 1 && d <= e + 6)});
		end
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial
	begin
		repeat (12) @(posedge sysClk);
		rstN <= 1'b1;
		regs();
		ovr();
		pwm(t16c_pkg::MODE_FAST8, t16c_pkg::ACT_CLEAR, 16'h0080, 256, 129);
		pwm(t16c_pkg::MODE_FAST8, t16c_pkg::ACT_SET, 16'h0080, 256, 127);
		pwm(t16c_pkg::MODE_PC8, t16c_pkg::ACT_CLEAR, 16'h0040, 510, 128);
		pwm(t16c_pkg::MODE_FAST9, t16c_pkg::ACT_CLEAR, 16'h0100, 512, 257);
		pwm(t16c_pkg::MODE_CTC_A, t16c_pkg::ACT_TOGGLE, 16'h003F, 128, 64);
		capt(1'b1, 3, 1'b1, 1'b0, 1'b0);
		capt(1'b1, 8, 1'b1, 1'b1, 1'b1);
		capt(1'b0, 2, 1'b0, 1'b1, 1'b0);
		ticks();
		ext();
		wrap_up();
	end
	// whole run is near 17500 cycles, so over twice that means a hang
	initial
	begin
		repeat (40000) @(posedge sysClk);
		numErrors++;
		wrap_up();
	end
endmodule // tb
